/* File: hw/jta_pkg.sv */
// constants, state encodings and carrier types of the test access block
// assumes a single 40 MHz system clock; every other rate is sampled on it
// Overview of operation
// - one standard boundary-scan port for I/O pins
// - instruction register 4 bits, data register 32
// - path onward to chip port reaching tile
// - test reset held low keeps logic reset
// - identity word: version, part, maker, bit0 one
// - user word: user id, unused, silicon revision
// - user id copies security bits 22 to 31
// - global reset active low, asserts asynchronously
// - boot only after PLL lock returns
// - security bit 0 disables tile access path
// - security bit 13 blocks fuse memory access
package jta_pkg;

	// timing
	localparam int CLK_PERIOD_NS = 25;                  // system clock period
	localparam int RST_HOLD_NS   = 100;                 // least reset hold by the far side
	localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SUPPLY_WAIT_US = 1000;               // far-side release delay, not counted here

	// register widths
	localparam int IR_LEN = 4;                          // instruction register length
	localparam int DR_LEN = 32;                         // data register length

	// instruction codes
	localparam logic [IR_LEN-1:0] IR_EXTEST   = 4'h0;   // drive pins from boundary cells
	localparam logic [IR_LEN-1:0] IR_IDCODE   = 4'h1;   // identity word
	localparam logic [IR_LEN-1:0] IR_USERCODE = 4'h2;   // user word
	localparam logic [IR_LEN-1:0] IR_SAMPLE   = 4'h3;   // sample / preload boundary cells
	localparam logic [IR_LEN-1:0] IR_CHIP     = 4'h4;   // onward chip port to tile
	localparam logic [IR_LEN-1:0] IR_OTP      = 4'h5;   // fuse memory access port
	localparam logic [IR_LEN-1:0] IR_BYPASS   = 4'hf;   // one-bit bypass
	localparam logic [IR_LEN-1:0] IR_CAPTURE  = 4'h1;   // pattern loaded in capture-ir
	localparam logic [IR_LEN-1:0] IR_RESET    = 4'h1;   // instruction after test reset

	// word layouts
	localparam int UID_LSB = 22;                        // user id low bit, word and security
	localparam int UID_MSB = 31;                        // user id high bit
	localparam int REV_MSB = 7;                         // silicon revision occupies [7:0]
	localparam int VER_LSB = 28;                        // identity version field [31:28]
	localparam int PART_LSB = 12;                       // identity part field [27:12]
	localparam int MAKER_LSB = 1;                       // identity maker field [11:1]

	// security register bits
	localparam int SEC_JTAG_OFF     = 0;                // tile path disabled
	localparam int SEC_OTP_BOOT     = 5;                // boot from fuse memory
	localparam int SEC_JTAG_OTP_OFF = 13;               // fuse memory path disabled

	// reset values
	localparam logic [DR_LEN-1:0] WORD_RESET = 32'h0000_0000;

	// test access states, one-hot
	typedef enum logic [15:0] {
		TS_RESET      = 16'h0001,
		TS_IDLE       = 16'h0002,
		TS_SEL_DR     = 16'h0004,
		TS_CAP_DR     = 16'h0008,
		TS_SHIFT_DR   = 16'h0010,
		TS_EXIT1_DR   = 16'h0020,
		TS_PAUSE_DR   = 16'h0040,
		TS_EXIT2_DR   = 16'h0080,
		TS_UPD_DR     = 16'h0100,
		TS_SEL_IR     = 16'h0200,
		TS_CAP_IR     = 16'h0400,
		TS_SHIFT_IR   = 16'h0800,
		TS_EXIT1_IR   = 16'h1000,
		TS_PAUSE_IR   = 16'h2000,
		TS_EXIT2_IR   = 16'h4000,
		TS_UPD_IR     = 16'h8000
	} jta_tap_state_t;

	// boot sequencing states, one-hot
	typedef enum logic [2:0] {
		BS_HELD = 3'h1,
		BS_LOCK = 3'h2,
		BS_RUN  = 3'h4
	} jta_boot_state_t;

	// pins sampled from outside the clock domain
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
		logic pll_lock;
	} jta_pins_t;

	// one-cycle strobes of the data-register path
	typedef struct packed {
		logic capture;
		logic shift;
		logic update;
	} jta_dr_ctl_t;

endpackage

/* File: hw/jta_scan_port.sv */
// one 32-bit scan register with capture, shift and update
// assumes strobes are one-cycle pulses on the system clock
`timescale 1ns/1ps
module jta_scan_port #(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 clr_i,
	// control
	input  wire logic                 sel_i,
	input  wire jta_pkg::jta_dr_ctl_t ctl_i,
	input  wire logic                 tdi_i,
	input  wire logic [W-1:0]         cap_word_i,
	// results
	output logic                      so_o,
	output logic [W-1:0]              upd_word_o,
	output logic                      upd_stb_o
);
	logic [W-1:0] sr;                       // shift stage

	// capture parallel word, then shift toward bit 0
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clr_i) begin
			sr <= '0;
		end else if (sel_i && ctl_i.capture) begin
			sr <= cap_word_i;
		end else if (sel_i && ctl_i.shift) begin
			sr <= {tdi_i, sr[W-1:1]};
		end
	end

	// update latch holds until the next update or a clear, so the far side sees a stable word
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clr_i) begin
			upd_word_o <= '0;
			upd_stb_o  <= 1'b0;
		end else begin
			upd_stb_o <= sel_i && ctl_i.update;
			if (sel_i && ctl_i.update) begin
				upd_word_o <= sr;
			end
		end
	end

	assign so_o = sr[0];
endmodule

/* File: hw/jta_top.sv */
// test access port with onward chip and fuse paths plus global reset sequencing
// assumes pin inputs are asynchronous; tile, security and pin words are on CLK_I
`timescale 1ns/1ps
module jta_top #(
	parameter int              NPINS      = 8,        // boundary cells
	parameter logic [3:0]      ID_VERSION = 4'h0,     // arbitrary value
	parameter logic [15:0]     ID_PART    = 16'h1234, // arbitrary value
	parameter logic [10:0]     ID_MAKER   = 11'h0a5,  // arbitrary value
	parameter logic [7:0]      SILICON_REV = 8'h01    // arbitrary value
) (
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RST_N_I,
	// test pins
	input  wire logic              TCK_I,
	input  wire logic              TMS_I,
	input  wire logic              TDI_I,
	input  wire logic              TRST_N_I,
	output logic                   TDO_O,
	output logic                   TDO_OE_O,
	// global reset and boot
	input  wire logic              CHIP_RST_N_I,
	input  wire logic              PLL_LOCK_I,
	output logic                   CORE_RST_N_O,
	output logic                   BOOT_START_O,
	output logic                   BOOT_FROM_OTP_O,
	// security word of the first tile
	input  wire logic [31:0]       SEC_REG_I,
	// tile debug path
	input  wire logic [31:0]       TILE_STATUS_I,
	output logic      [31:0]       TILE_CMD_O,
	output logic                   TILE_CMD_STB_O,
	// fuse memory path
	input  wire logic [31:0]       OTP_RDATA_I,
	output logic      [31:0]       OTP_CMD_O,
	output logic                   OTP_CMD_STB_O,
	// boundary cells
	input  wire logic [NPINS-1:0]  PIN_IN_I,
	output logic      [NPINS-1:0]  PIN_DRIVE_O,
	output logic                   EXTEST_O
);
	jta_pkg::jta_pins_t       raw_pins;     // pins as they arrive
	jta_pkg::jta_pins_t       s1, s2, s3;   // three-stage sampler
	jta_pkg::jta_pins_t       pins;         // filtered pin levels
	logic                     tck_q;        // last filtered clock level
	logic                     tck_rise;     // test clock rising edge
	logic                     tck_fall;     // test clock falling edge
	logic                     test_clr;     // test reset held
	jta_pkg::jta_tap_state_t  state;        // test access state
	jta_pkg::jta_tap_state_t  next_state;
	logic [3:0]               ir_sr;        // instruction shift stage
	logic [3:0]               ir;           // current instruction
	logic [31:0]              dr;           // identity / user shift stage
	logic                     bypass;       // bypass cell
	logic [NPINS-1:0]         bsr;          // boundary shift stage
	jta_pkg::jta_dr_ctl_t     ctl;          // data-register strobes
	logic                     tile_ok;      // tile path allowed
	logic                     otp_ok;       // fuse path allowed
	logic                     sel_chip;
	logic                     sel_otp;
	logic                     chip_so;
	logic                     otp_so;
	logic                     dr_so;        // selected data-register output
	logic [31:0]              id_word;
	logic [31:0]              user_word;
	logic                     rst_meta;     // global reset synchroniser
	logic                     rst_sync;
	jta_pkg::jta_boot_state_t boot;

	assign raw_pins = '{tck: TCK_I, tms: TMS_I, tdi: TDI_I, trst_n: TRST_N_I,
		pll_lock: PLL_LOCK_I};

	// three flops per pin; a level is taken only when the last two agree
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			pins <= '0;
		end else begin
			s1 <= raw_pins;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < $bits(jta_pkg::jta_pins_t); i++) begin
				if (s2[i] == s3[i]) begin
					pins[i] <= s3[i];
				end
			end
		end
	end

	// test clock edge finder; all test state moves only here
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			tck_q <= 1'b0;
		end else begin
			tck_q <= pins.tck;
		end
	end
	assign tck_rise = pins.tck && !tck_q;
	assign tck_fall = !pins.tck && tck_q;
	assign test_clr = !pins.trst_n;

	// state walk of the boundary-scan controller
	always_comb begin
		next_state = state;
		case (state)
			jta_pkg::TS_RESET:    next_state = pins.tms ? jta_pkg::TS_RESET : jta_pkg::TS_IDLE;
			jta_pkg::TS_IDLE:     next_state = pins.tms ? jta_pkg::TS_SEL_DR : jta_pkg::TS_IDLE;
			jta_pkg::TS_SEL_DR:   next_state = pins.tms ? jta_pkg::TS_SEL_IR : jta_pkg::TS_CAP_DR;
			jta_pkg::TS_CAP_DR:   next_state = pins.tms ? jta_pkg::TS_EXIT1_DR : jta_pkg::TS_SHIFT_DR;
			jta_pkg::TS_SHIFT_DR: next_state = pins.tms ? jta_pkg::TS_EXIT1_DR : jta_pkg::TS_SHIFT_DR;
			jta_pkg::TS_EXIT1_DR: next_state = pins.tms ? jta_pkg::TS_UPD_DR : jta_pkg::TS_PAUSE_DR;
			jta_pkg::TS_PAUSE_DR: next_state = pins.tms ? jta_pkg::TS_EXIT2_DR : jta_pkg::TS_PAUSE_DR;
			jta_pkg::TS_EXIT2_DR: next_state = pins.tms ? jta_pkg::TS_UPD_DR : jta_pkg::TS_SHIFT_DR;
			jta_pkg::TS_UPD_DR:   next_state = pins.tms ? jta_pkg::TS_SEL_DR : jta_pkg::TS_IDLE;
			jta_pkg::TS_SEL_IR:   next_state = pins.tms ? jta_pkg::TS_RESET : jta_pkg::TS_CAP_IR;
			jta_pkg::TS_CAP_IR:   next_state = pins.tms ? jta_pkg::TS_EXIT1_IR : jta_pkg::TS_SHIFT_IR;
			jta_pkg::TS_SHIFT_IR: next_state = pins.tms ? jta_pkg::TS_EXIT1_IR : jta_pkg::TS_SHIFT_IR;
			jta_pkg::TS_EXIT1_IR: next_state = pins.tms ? jta_pkg::TS_UPD_IR : jta_pkg::TS_PAUSE_IR;
			jta_pkg::TS_PAUSE_IR: next_state = pins.tms ? jta_pkg::TS_EXIT2_IR : jta_pkg::TS_PAUSE_IR;
			jta_pkg::TS_EXIT2_IR: next_state = pins.tms ? jta_pkg::TS_UPD_IR : jta_pkg::TS_SHIFT_IR;
			jta_pkg::TS_UPD_IR:   next_state = pins.tms ? jta_pkg::TS_SEL_DR : jta_pkg::TS_IDLE;
			default:              next_state = jta_pkg::TS_RESET;
		endcase
	end

	// controller state; a held test reset pins it in reset
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || test_clr) begin
			state <= jta_pkg::TS_RESET;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

	// instruction path, 4 bits
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || test_clr || state == jta_pkg::TS_RESET) begin
			ir_sr <= jta_pkg::IR_RESET;
			ir    <= jta_pkg::IR_RESET;
		end else if (tck_rise && state == jta_pkg::TS_CAP_IR) begin
			ir_sr <= jta_pkg::IR_CAPTURE;
		end else if (tck_rise && state == jta_pkg::TS_SHIFT_IR) begin
			ir_sr <= {pins.tdi, ir_sr[3:1]};
		end else if (tck_fall && state == jta_pkg::TS_UPD_IR) begin
			ir <= ir_sr;
		end
	end

	// data strobes: capture and shift on rise, update on fall
	assign ctl.capture = tck_rise && state == jta_pkg::TS_CAP_DR;
	assign ctl.shift   = tck_rise && state == jta_pkg::TS_SHIFT_DR;
	assign ctl.update  = tck_fall && state == jta_pkg::TS_UPD_DR;

	// security gating of the inner paths
	assign tile_ok  = !SEC_REG_I[jta_pkg::SEC_JTAG_OFF];
	assign otp_ok   = tile_ok && !SEC_REG_I[jta_pkg::SEC_JTAG_OTP_OFF];
	assign sel_chip = ir == jta_pkg::IR_CHIP && tile_ok;
	assign sel_otp  = ir == jta_pkg::IR_OTP && otp_ok;

	// fixed words
	assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
	assign user_word = {SEC_REG_I[jta_pkg::UID_MSB:jta_pkg::UID_LSB],
		14'h0000, SILICON_REV};

	// identity, user and bypass cells; a blocked path falls back to bypass
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || test_clr) begin
			dr     <= jta_pkg::WORD_RESET;
			bypass <= 1'b0;
		end else if (ctl.capture) begin
			bypass <= 1'b0;
			case (ir)
				jta_pkg::IR_IDCODE:   dr <= id_word;
				jta_pkg::IR_USERCODE: dr <= user_word;
				default:              dr <= jta_pkg::WORD_RESET;
			endcase
		end else if (ctl.shift) begin
			dr     <= {pins.tdi, dr[31:1]};
			bypass <= pins.tdi;
		end
	end

	// boundary cells: capture pins, update drive word
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || test_clr) begin
			bsr         <= '0;
			PIN_DRIVE_O <= '0;
			EXTEST_O    <= 1'b0;
		end else begin
			EXTEST_O <= ir == jta_pkg::IR_EXTEST;
			if (ir == jta_pkg::IR_EXTEST || ir == jta_pkg::IR_SAMPLE) begin
				if (ctl.capture) begin
					bsr <= PIN_IN_I;
				end else if (ctl.shift) begin
					bsr <= {pins.tdi, bsr[NPINS-1:1]};
				end else if (ctl.update) begin
					PIN_DRIVE_O <= bsr;
				end
			end
		end
	end

	// onward chip port toward the tile
	jta_scan_port #(.W(jta_pkg::DR_LEN)) u_chip (
		.clk_i      (CLK_I),
		.rst_n_i    (RST_N_I),
		.clr_i      (test_clr),
		.sel_i      (sel_chip),
		.ctl_i      (ctl),
		.tdi_i      (pins.tdi),
		.cap_word_i (TILE_STATUS_I),
		.so_o       (chip_so),
		.upd_word_o (TILE_CMD_O),
		.upd_stb_o  (TILE_CMD_STB_O)
	);

	// fuse memory port
	jta_scan_port #(.W(jta_pkg::DR_LEN)) u_otp (
		.clk_i      (CLK_I),
		.rst_n_i    (RST_N_I),
		.clr_i      (test_clr),
		.sel_i      (sel_otp),
		.ctl_i      (ctl),
		.tdi_i      (pins.tdi),
		.cap_word_i (OTP_RDATA_I),
		.so_o       (otp_so),
		.upd_word_o (OTP_CMD_O),
		.upd_stb_o  (OTP_CMD_STB_O)
	);

	// data output select
	always_comb begin
		case (ir)
			jta_pkg::IR_IDCODE,
			jta_pkg::IR_USERCODE: dr_so = dr[0];
			jta_pkg::IR_EXTEST,
			jta_pkg::IR_SAMPLE:   dr_so = bsr[0];
			jta_pkg::IR_CHIP:     dr_so = sel_chip ? chip_so : bypass;
			jta_pkg::IR_OTP:      dr_so = sel_otp ? otp_so : bypass;
			default:              dr_so = bypass;
		endcase
	end

	// test data out changes on the falling edge, driven only while shifting
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || test_clr) begin
			TDO_O    <= 1'b0;
			TDO_OE_O <= 1'b0;
		end else if (tck_fall) begin
			TDO_O    <= state == jta_pkg::TS_SHIFT_IR ? ir_sr[0] : dr_so;
			TDO_OE_O <= state == jta_pkg::TS_SHIFT_IR || state == jta_pkg::TS_SHIFT_DR;
		end
	end

	// global reset: asserts at once, releases through two flops
	always_ff @(posedge CLK_I or negedge CHIP_RST_N_I) begin
		if (!CHIP_RST_N_I) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// boot sequencing; core reset also drops asynchronously
	always_ff @(posedge CLK_I or negedge CHIP_RST_N_I) begin
		if (!CHIP_RST_N_I) begin
			boot            <= jta_pkg::BS_HELD;
			CORE_RST_N_O    <= 1'b0;
			BOOT_START_O    <= 1'b0;
			BOOT_FROM_OTP_O <= 1'b0;
		end else if (!RST_N_I || !rst_sync) begin
			boot            <= jta_pkg::BS_HELD;
			CORE_RST_N_O    <= 1'b0;
			BOOT_START_O    <= 1'b0;
			BOOT_FROM_OTP_O <= 1'b0;
		end else begin
			BOOT_START_O <= 1'b0;
			case (boot)
				jta_pkg::BS_HELD: boot <= jta_pkg::BS_LOCK;
				jta_pkg::BS_LOCK: begin
					// lock may lag the release by a long time; nothing starts before it
					if (pins.pll_lock) begin
						boot            <= jta_pkg::BS_RUN;
						CORE_RST_N_O    <= 1'b1;
						BOOT_START_O    <= 1'b1;
						BOOT_FROM_OTP_O <= SEC_REG_I[jta_pkg::SEC_OTP_BOOT];
					end
				end
				jta_pkg::BS_RUN:  boot <= jta_pkg::BS_RUN;
				default:          boot <= jta_pkg::BS_HELD;
			endcase
		end
	end
endmodule

/* File: tb/jta_host_model.sv */
// host side of the test port: paces test clock, mode, data and test reset
// assumes the system clock is passed in only to time the test clock edges
`timescale 1ns/1ps
module jta_host_model (
	// pacing clock
	input  wire logic clk_i,
	// test pins
	input  wire logic tdo_i,
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	output logic      trst_n_o
);
	// test clock stands still low outside frames
	initial begin
		tck_o    = 1'b0;
		tms_o    = 1'b1;
		tdi_o    = 1'b0;
		trst_n_o = 1'b0;
	end

	// wait n system clocks, then step just past the edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// one 200 ns test clock period; tdo read mid high phase, as the pin sampler delays it
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		tms_o = tms;
		tdi_o = tdi;
		step(4);
		tck_o = 1'b1;
		step(2);
		tdo = tdo_i;
		step(2);
		tck_o = 1'b0;
	endtask

	// release test reset well past 100 ns, then walk to idle
	task automatic release_trst();
		logic d;
		trst_n_o = 1'b1;
		step(8);
		for (int i = 0; i < 6; i++) begin
			tick(i < 5, ~tdi_o, d);
		end
	endtask

	// one scan from idle back to idle, lsb first; idle data toggles so no stale level lingers
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
			output logic [31:0] dout);
		logic d;
		dout = '0;
		tick(1'b1, ~tdi_o, d);
		if (ir) begin
			tick(1'b1, ~tdi_o, d);
		end
		tick(1'b0, ~tdi_o, d);
		tick(1'b0, ~tdi_o, d);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], d);
			dout[i] = d;
		end
		tick(1'b1, ~tdi_o, d);
		tick(1'b0, ~tdi_o, d);
	endtask
endmodule

/* File: tb/jta_top_sva.sv */
// port-level checks of the test access block
// assumes one system clock domain with its synchronous active-low reset
`timescale 1ns/1ps
module jta_top_sva (
	// clock and reset
	input wire logic        CLK_I,
	input wire logic        RST_N_I,
	// test pins
	input wire logic        TCK_I,
	input wire logic        TRST_N_I,
	input wire logic        TDO_O,
	input wire logic        TDO_OE_O,
	// global reset and boot
	input wire logic        CHIP_RST_N_I,
	input wire logic        PLL_LOCK_I,
	input wire logic        CORE_RST_N_O,
	input wire logic        BOOT_START_O,
	input wire logic        BOOT_FROM_OTP_O,
	input wire logic [31:0] SEC_REG_I,
	// onward paths
	input wire logic        TILE_CMD_STB_O,
	input wire logic        OTP_CMD_STB_O
);
	default clocking cb
		@(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	// six cycles covers the pin sampler latency
	a_trst_holds_off: assert property (!TRST_N_I [*6] |-> !TDO_OE_O && !TDO_O)
		else $error("test output active under test reset");
	a_core_rst_async: assert property (!CHIP_RST_N_I |-> !CORE_RST_N_O && !BOOT_START_O)
		else $error("core reset not low with global reset low");
	a_boot_after_lock: assert property ($rose(CORE_RST_N_O) |->
			$past(PLL_LOCK_I) && $past(PLL_LOCK_I, 3) && $past(CHIP_RST_N_I, 3))
		else $error("core left reset without settled lock");
	a_no_lock_held: assert property (!CORE_RST_N_O && !PLL_LOCK_I |=> !CORE_RST_N_O)
		else $error("core left reset while lock low");
	a_boot_one_pulse: assert property (BOOT_START_O |-> $rose(CORE_RST_N_O) ##1 !BOOT_START_O)
		else $error("boot start not a single pulse at core release");
	a_boot_mode_sel: assert property (BOOT_START_O |-> BOOT_FROM_OTP_O == SEC_REG_I[5])
		else $error("boot source differs from secure boot bit");
	a_tile_path_off: assert property (SEC_REG_I[0] |-> !TILE_CMD_STB_O)
		else $error("tile command strobe while path disabled");
	a_fuse_path_off: assert property (SEC_REG_I[0] || SEC_REG_I[13] |-> !OTP_CMD_STB_O)
		else $error("fuse command strobe while path disabled");
	a_cmd_stb_pulse: assert property (TILE_CMD_STB_O || OTP_CMD_STB_O |=>
			!TILE_CMD_STB_O && !OTP_CMD_STB_O)
		else $error("command strobe longer than one cycle");
	// outside test reset the port moves only on test clock edges
	a_tdo_still_tck: assert property ((!TCK_I && TRST_N_I) [*8] |->
			$stable(TDO_O) && $stable(TDO_OE_O))
		else $error("test output moved with test clock still");
endmodule

bind jta_top jta_top_sva u_sva (
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .TCK_I(TCK_I), .TRST_N_I(TRST_N_I),
	.TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O), .CHIP_RST_N_I(CHIP_RST_N_I),
	.PLL_LOCK_I(PLL_LOCK_I), .CORE_RST_N_O(CORE_RST_N_O), .BOOT_START_O(BOOT_START_O),
	.BOOT_FROM_OTP_O(BOOT_FROM_OTP_O), .SEC_REG_I(SEC_REG_I),
	.TILE_CMD_STB_O(TILE_CMD_STB_O), .OTP_CMD_STB_O(OTP_CMD_STB_O)
);

/* File: tb/jtag_test_access_and_reset_tb.sv */
// self-checking bench of the test access block with a host model on the test pins
// assumes the design's sampler latencies; every wait is bounded
`timescale 1ns/1ps
module jtag_test_access_and_reset_tb;
	localparam int          NP  = 8;
	localparam logic [3:0]  VER = 4'h2;     // arbitrary value
	localparam logic [15:0] PRT = 16'h0c3d; // arbitrary value
	localparam logic [10:0] MKR = 11'h15b;  // arbitrary value
	localparam logic [7:0]  REV = 8'h7e;    // arbitrary value

	logic          clk = 1'b0;
	logic          rst_n, chip_rst_n, pll_lock, tck, tms, tdi, trst_n, tdo, tdo_oe;
	logic          core_rst_n, boot_start, boot_otp, tile_stb, otp_stb, extest;
	logic [31:0]   sec, tile_status, tile_cmd, otp_rdata, otp_cmd;
	logic [NP-1:0] pin_in, pin_drive;
	int            err_total = 0, n_tests = 0, seed = 32'h1a44;
	int            stb_tile = 0, stb_otp = 0, exp_tile = 0, exp_otp = 0;
	int            oe_cyc = 0;  // clocks with test output enabled

	always #12.5 clk = ~clk;

	jta_top #(.NPINS(NP), .ID_VERSION(VER), .ID_PART(PRT), .ID_MAKER(MKR),
		.SILICON_REV(REV)) u_dut (
		.CLK_I(clk), .RST_N_I(rst_n), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
		.TRST_N_I(trst_n), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .CHIP_RST_N_I(chip_rst_n),
		.PLL_LOCK_I(pll_lock), .CORE_RST_N_O(core_rst_n), .BOOT_START_O(boot_start),
		.BOOT_FROM_OTP_O(boot_otp), .SEC_REG_I(sec), .TILE_STATUS_I(tile_status),
		.TILE_CMD_O(tile_cmd), .TILE_CMD_STB_O(tile_stb), .OTP_RDATA_I(otp_rdata),
		.OTP_CMD_O(otp_cmd), .OTP_CMD_STB_O(otp_stb), .PIN_IN_I(pin_in),
		.PIN_DRIVE_O(pin_drive), .EXTEST_O(extest));

	jta_host_model u_host (.clk_i(clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
		.trst_n_o(trst_n));

	// strobe counts, compared with the bench's expected counts
	always @(posedge clk) begin
		if (tile_stb === 1'b1) stb_tile++;
		if (otp_stb === 1'b1) stb_otp++;
		if (tdo_oe === 1'b1) oe_cyc++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (err_total == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// bounded wait for the boot pulse; a miss ends the run
	task automatic wait_boot();
		int k;
		k = 0;
		while (boot_start !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k == 40) begin
			err_total++;
			results();
		end
	endtask

	initial begin
		logic [31:0] d, q, w;
		rst_n = 1'b0;
		chip_rst_n = 1'b0;
		pll_lock = 1'b0;
		sec = '0;
		tile_status = '0;
		otp_rdata = '0;
		pin_in = '0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		// global reset kept low 1 ms past supply good, then two boots
		repeat (40000) @(posedge clk);
		#1;
		for (int b = 0; b < 2; b++) begin
			sec = {26'h0, b[0], 5'h0};
			chip_rst_n = 1'b1;
			repeat (10) @(posedge clk);
			#1;
			check(32'(core_rst_n), 32'h0);
			pll_lock = 1'b1;
			wait_boot();
			check(32'(core_rst_n), 32'h1);
			check(32'(boot_otp), 32'(b[0]));
			chip_rst_n = 1'b0;
			pll_lock = 1'b0;
			#2;
			check(32'(core_rst_n), 32'h0);
			repeat (6) @(posedge clk);
			#1;
		end
		// test clock edges under test reset change nothing
		u_host.scan(1'b0, 2, 32'h3, d);
		check(d, 32'h0);
		u_host.release_trst();
		// instruction after test reset reads the identity word
		w = $random(seed);
		u_host.scan(1'b0, 32, w, d);
		check(d, {VER, PRT, MKR, 1'b1});
		// enable stands only while shifting: 32 bits at 8 clocks each, nothing before
		check(32'(oe_cyc), 32'h100);
		// user word, first pass as an unprogrammed part
		for (int i = 0; i < 3; i++) begin
			w = $random(seed);
			sec = (i == 0) ? 32'h0 : (w & 32'hffff_dffe);
			u_host.scan(1'b1, 4, {28'h0, jta_pkg::IR_USERCODE}, q);
			check(q, 32'h1);
			u_host.scan(1'b0, 32, w, d);
			check(d, {sec[31:22], 14'h0, REV});
		end
		// tile and fuse paths, open then blocked by security bits
		for (int k = 0; k < 4; k++) begin
			w = $random(seed);
			tile_status = $random(seed);
			otp_rdata = $random(seed);
			sec = (k == 1) ? 32'h1 : (k == 3) ? 32'h2000 : 32'h0;
			q = (k < 2) ? {28'h0, jta_pkg::IR_CHIP} : {28'h0, jta_pkg::IR_OTP};
			u_host.scan(1'b1, 4, q, q);
			u_host.scan(1'b0, 32, w, d);
			if (!k[0]) begin
				if (k < 2) exp_tile++;
				else exp_otp++;
				check((k < 2) ? tile_cmd : otp_cmd, w);
			end
			check(d, k[0] ? {w[30:0], 1'b0} : (k < 2) ? tile_status : otp_rdata);
			check(32'(stb_tile), 32'(exp_tile));
			check(32'(stb_otp), 32'(exp_otp));
		end
		// boundary cells drive and sample pins, then bypass
		pin_in = NP'($random(seed));
		w = $random(seed);
		u_host.scan(1'b1, 4, {28'h0, jta_pkg::IR_EXTEST}, q);
		check(32'(extest), 32'h1);
		u_host.scan(1'b0, NP, w, d);
		check(32'(pin_drive), 32'(w[NP-1:0]));
		check(d, 32'(pin_in));
		u_host.scan(1'b1, 4, {28'h0, jta_pkg::IR_BYPASS}, q);
		check(32'(extest), 32'h0);
		u_host.scan(1'b0, 32, w, d);
		check(d, {w[30:0], 1'b0});
		results();
	end
endmodule
